// File: can_tx_defs.svh
// register map, field positions and limits of the can transmit buffer block
`ifndef CAN_TX_DEFS_SVH
`define CAN_TX_DEFS_SVH
`define OFS_STATUS      8'h00
`define OFS_TX_COUNT    8'h04
`define OFS_MODCTRL     8'h08
`define OFS_RXERRCNT    8'h0c
`define OFS_BUF_BASE    8'h40
`define BUF_STRIDE      8'h40
`define BOFS_CON        4'h0
`define BOFS_SIDH       4'h1
`define BOFS_SIDL       4'h2
`define BOFS_EIDH       4'h3
`define BOFS_EIDL       4'h4
`define BOFS_DLC        4'h5
`define BOFS_DATA0      4'h8
`define CON_ABT         6
`define CON_LARB        5
`define CON_ERR         4
`define CON_REQ         3
`define IDL_EXT_ENABLE  3
`define DLC_RTR         6
`define MOD_ABORT_ALL   4
`define DLC_MAX         4'h8
`define CNT_PASSIVE     8'h7f
`define CNT_WARN        8'h5f
`define TEC_MAX         8'hff
`define OVF0_BIT        7
`define OVF1_BIT        6
`define RECOVERY_RUNS   8'h80
`define NUM_BUFS        3
`define AXI_OKAY        2'b00
`define AXI_SLVERR      2'b10
`endif

// File: can_tx_pkg.sv
// types shared by the can transmit buffer block
package can_tx_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_SEND = 4'b0100,
    ST_DONE = 4'b1000
  } tx_state_e;
  typedef logic [1:0] buf_idx_t;
endpackage

// File: can_tx_buffers.sv
// transmit buffers, communication status and transmit error counter
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "can_tx_defs.svh"
// Functional notes
// - rx buffer 0 overflow flag set by event, cleared by software write-one.
// - rx buffer 1 overflow flag set by event, cleared by software write-one.
// - tx bus-off flag set when transmit error counter overflows past 255.
// - tx error-passive flag high while transmit error count above 127.
// - rx error-passive flag high while receive error count above 127.
// - tx warning high while transmit error count in 96..127.
// - rx warning high while receive error count in 96..127.
// - combined warning is tx warning or rx warning.
// - setting request queues buffer and clears aborted, lost-arb, error flags.
// - request clears itself after successful sending.
// - software clearing a set request aborts that buffer.
// - aborted flag set when buffer transmission aborted.
// - lost-arbitration flag set when buffer loses arbitration.
// - bus-error flag set when bus error hits buffer's message.
// - two-bit priority per buffer, 11 highest, 00 lowest.
// - priority orders buffers only, never alters identifier.
// - extended enable sends 29-bit id, standard bits on top; else 11-bit.
// - high id byte gives id 10..3, or 28..21 in extended mode.
// - frame rtr bit equals buffer remote-request setting.
// - length codes 0..8 mean 0..8 bytes; 9..15 reserved.
// - three buffers, each with eight data byte registers.
// - read-only tx error counter; cleared after 128 recovery runs.
// - abort-all bit aborts pending transmissions in every buffer.
module can_tx_buffers
  import can_tx_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_buf0_overflow_event,
  input  wire logic        rx_buf1_overflow_event,
  input  wire logic [7:0]  rx_error_count,
  output logic             frame_valid,
  input  wire logic        frame_ready,
  output logic [10:0]      frame_standard_id,
  output logic [17:0]      frame_extended_id,
  output logic             frame_extended,
  output logic             frame_remote,
  output logic [3:0]       frame_length,
  output logic [63:0]      frame_data,
  output buf_idx_t         frame_buffer,
  input  wire logic        frame_sent,
  input  wire logic        frame_lost_arbitration,
  input  wire logic        frame_bus_error,
  input  wire logic        abort_ack,
  output logic             abort_request,
  input  wire logic        tec_increment_8,
  input  wire logic        tec_increment_1,
  input  wire logic        tec_decrement,
  input  wire logic        recessive_run_11
);
  localparam int NB = `NUM_BUFS;

  logic [7:0]  id_high_reg  [NB];
  logic [7:0]  id_low_reg   [NB];
  logic [7:0]  eid_high_reg [NB];
  logic [7:0]  eid_low_reg  [NB];
  logic [7:0]  dlc_reg      [NB];
  logic [7:0]  data_reg     [NB][8];
  logic [NB-1:0] req_reg, abt_reg, larb_reg, err_reg;
  logic [1:0]  pri_reg      [NB];
  logic        ovf0_reg, ovf1_reg, abort_all_reg, bus_off_reg;
  logic [7:0]  tec_reg, runs_reg;
  tx_state_e   state_reg;
  buf_idx_t    cur_reg;

  // write channel: address and data taken in either order
  logic        aw_held_reg, w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_go;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_byte;
  logic        wr_hit, wr_lane0;
  buf_idx_t    wr_buf;
  logic [3:0]  wr_sub;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_go   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_addr = aw_addr_reg;
  assign wr_byte = w_data_reg[7:0];
  assign wr_lane0 = w_strb_reg[0];
  assign wr_buf  = buf_idx_t'((wr_addr - `OFS_BUF_BASE) >> 6);
  assign wr_sub  = wr_addr[5:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic addr_hit(input logic [7:0] a);
    logic [7:0] b;
    b = a - `OFS_BUF_BASE;
    if (a[1:0] != 2'b00)
      return 1'b0;
    if (a == `OFS_STATUS || a == `OFS_TX_COUNT || a == `OFS_MODCTRL || a == `OFS_RXERRCNT)
      return 1'b1;
    if (a < `OFS_BUF_BASE || b >= 8'(NB * 64))
      return 1'b0;
    return (b[5:2] <= `BOFS_DLC) || (b[5:2] >= `BOFS_DATA0);
  endfunction

  assign wr_hit = addr_hit(wr_addr);

  logic buf_wr, ctrl_wr;
  assign buf_wr  = wr_go && wr_hit && wr_lane0 && wr_addr >= `OFS_BUF_BASE;
  assign ctrl_wr = wr_go && wr_hit && wr_lane0;

  // priority selection among pending buffers
  logic       any_pending;
  buf_idx_t   pick;
  always_comb begin
    any_pending = 1'b0;
    pick = 2'd0;
    for (int i = 0; i < NB; i++) begin
      if (req_reg[i] && (!any_pending || pri_reg[i] >= pri_reg[pick])) begin
        any_pending = 1'b1;
        pick = buf_idx_t'(i);
      end
    end
  end

  // per-buffer payload registers, written by software only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NB; i++) begin
        id_high_reg[i]  <= 8'h00;
        id_low_reg[i]   <= 8'h00;
        eid_high_reg[i] <= 8'h00;
        eid_low_reg[i]  <= 8'h00;
        dlc_reg[i]      <= 8'h00;
        pri_reg[i]      <= 2'b00;
        for (int j = 0; j < 8; j++)
          data_reg[i][j] <= 8'h00;
      end
    end else if (buf_wr) begin
      case (wr_sub)
        `BOFS_CON:  pri_reg[wr_buf]      <= wr_byte[1:0];
        `BOFS_SIDH: id_high_reg[wr_buf]  <= wr_byte;
        `BOFS_SIDL: id_low_reg[wr_buf]   <= wr_byte & 8'heb;
        `BOFS_EIDH: eid_high_reg[wr_buf] <= wr_byte;
        `BOFS_EIDL: eid_low_reg[wr_buf]  <= wr_byte;
        `BOFS_DLC:  dlc_reg[wr_buf]      <= wr_byte & 8'h4f;
        default:    data_reg[wr_buf][wr_sub[2:0]] <= wr_byte;
      endcase
    end
  end

  // an engine that accepts the frame at this edge counts as on the wire already
  logic abort_pending_reg, frame_end, wire_busy, abort_end;
  assign frame_end = state_reg == ST_SEND &&
                     (frame_sent || abort_ack || frame_lost_arbitration || frame_bus_error);
  assign wire_busy = (state_reg == ST_SEND && !frame_end) ||
                     (state_reg == ST_LOAD && frame_valid && frame_ready);
  // a pending abort also ends a failed frame, otherwise the buffer would retry
  assign abort_end = abort_ack ||
                     (abort_pending_reg && (frame_lost_arbitration || frame_bus_error));

  // request and per-buffer status; hardware sets win over software clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_reg  <= '0;
      abt_reg  <= '0;
      larb_reg <= '0;
      err_reg  <= '0;
    end else begin
      for (int i = 0; i < NB; i++) begin
        if (buf_wr && wr_sub == `BOFS_CON && wr_buf == buf_idx_t'(i)) begin
          if (wr_byte[`CON_REQ]) begin
            req_reg[i]  <= 1'b1;
            abt_reg[i]  <= 1'b0;
            larb_reg[i] <= 1'b0;
            err_reg[i]  <= 1'b0;
          end else if (req_reg[i]) begin
            // abort waits for the engine only if this buffer is on the wire
            if (!(wire_busy && cur_reg == buf_idx_t'(i))) begin
              req_reg[i] <= 1'b0;
              abt_reg[i] <= 1'b1;
            end
          end
        end
        if (abort_all_reg && req_reg[i] &&
            !(wire_busy && cur_reg == buf_idx_t'(i))) begin
          req_reg[i] <= 1'b0;
          abt_reg[i] <= 1'b1;
        end
      end
      if (state_reg == ST_SEND) begin
        if (frame_sent)
          req_reg[cur_reg] <= 1'b0;
        else if (abort_end) begin
          req_reg[cur_reg] <= 1'b0;
          abt_reg[cur_reg] <= 1'b1;
        end
        if (frame_lost_arbitration)
          larb_reg[cur_reg] <= 1'b1;
        if (frame_bus_error)
          err_reg[cur_reg] <= 1'b1;
      end
    end
  end

  // pending abort for the buffer on the wire, held until the engine answers
  always_ff @(posedge aclk) begin
    if (!aresetn)
      abort_pending_reg <= 1'b0;
    else if (!wire_busy)
      abort_pending_reg <= 1'b0;
    else if (abort_all_reg ||
             (buf_wr && wr_sub == `BOFS_CON && wr_buf == cur_reg && !wr_byte[`CON_REQ]))
      abort_pending_reg <= 1'b1;
  end
  assign abort_request = abort_pending_reg;

  // transmit sequencer feeding the protocol engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cur_reg   <= 2'd0;
    end else begin
      case (state_reg)
        ST_IDLE: if (any_pending && !bus_off_reg) begin
          cur_reg   <= pick;
          state_reg <= ST_LOAD;
        end
        ST_LOAD: if (!req_reg[cur_reg])
          state_reg <= ST_IDLE;
        else if (frame_ready)
          state_reg <= ST_SEND;
        ST_SEND: if (frame_sent || abort_ack || frame_lost_arbitration || frame_bus_error)
          state_reg <= ST_DONE;
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // frame fields are registered copies of the chosen buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_standard_id <= 11'h000;
      frame_extended_id <= 18'h00000;
      frame_extended    <= 1'b0;
      frame_remote      <= 1'b0;
      frame_length      <= 4'h0;
      frame_data        <= 64'h0;
      frame_buffer      <= 2'd0;
    end else if (state_reg == ST_IDLE && any_pending) begin
      frame_standard_id <= {id_high_reg[pick], id_low_reg[pick][7:5]};
      frame_extended    <= id_low_reg[pick][`IDL_EXT_ENABLE];
      frame_extended_id <= id_low_reg[pick][`IDL_EXT_ENABLE] ?
                           {id_low_reg[pick][1:0], eid_high_reg[pick], eid_low_reg[pick]} :
                           18'h00000;
      frame_remote      <= dlc_reg[pick][`DLC_RTR];
      // reserved length codes are sent as coded; engine caps data at eight bytes
      frame_length      <= dlc_reg[pick][3:0];
      for (int j = 0; j < 8; j++)
        frame_data[j*8 +: 8] <= data_reg[pick][j];
      frame_buffer      <= pick;
    end
  end
  assign frame_valid = (state_reg == ST_LOAD) && req_reg[cur_reg];

  // module control abort-all, self-clearing once nothing remains pending
  always_ff @(posedge aclk) begin
    if (!aresetn)
      abort_all_reg <= 1'b0;
    else if (ctrl_wr && wr_addr == `OFS_MODCTRL)
      abort_all_reg <= wr_byte[`MOD_ABORT_ALL];
    else if (abort_all_reg && req_reg == '0)
      abort_all_reg <= 1'b0;
  end

  // receive overflow flags, write one to clear, event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf0_reg <= 1'b0;
      ovf1_reg <= 1'b0;
    end else begin
      if (rx_buf0_overflow_event)
        ovf0_reg <= 1'b1;
      else if (ctrl_wr && wr_addr == `OFS_STATUS && wr_byte[`OVF0_BIT])
        ovf0_reg <= 1'b0;
      if (rx_buf1_overflow_event)
        ovf1_reg <= 1'b1;
      else if (ctrl_wr && wr_addr == `OFS_STATUS && wr_byte[`OVF1_BIT])
        ovf1_reg <= 1'b0;
    end
  end

  // transmit error counter with overflow into bus-off
  logic [8:0] tec_sum;
  always_comb begin
    tec_sum = {1'b0, tec_reg};
    if (tec_increment_8)
      tec_sum = tec_sum + 9'd8;
    else if (tec_increment_1)
      tec_sum = tec_sum + 9'd1;
    else if (tec_decrement && tec_reg != 8'h00)
      tec_sum = tec_sum - 9'd1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tec_reg     <= 8'h00;
      bus_off_reg <= 1'b0;
      runs_reg    <= 8'h00;
    end else if (bus_off_reg) begin
      // recovery: counter is held until enough idle runs have been seen
      if (recessive_run_11) begin
        if (runs_reg == `RECOVERY_RUNS - 8'h01) begin
          tec_reg     <= 8'h00;
          bus_off_reg <= 1'b0;
          runs_reg    <= 8'h00;
        end else
          runs_reg <= runs_reg + 8'h01;
      end
    end else begin
      // overflow pins the count at its top so passive stays on while bus-off
      tec_reg <= tec_sum[8] ? `TEC_MAX : tec_sum[7:0];
      if (tec_sum[8])
        bus_off_reg <= 1'b1;
    end
  end

  logic tx_warn, rx_warn;
  logic [7:0] comm_status;
  assign tx_warn = tec_reg > `CNT_WARN && tec_reg <= `CNT_PASSIVE;
  assign rx_warn = rx_error_count > `CNT_WARN && rx_error_count <= `CNT_PASSIVE;
  assign comm_status = {ovf0_reg, ovf1_reg, bus_off_reg,
                        tec_reg > `CNT_PASSIVE,
                        rx_error_count > `CNT_PASSIVE,
                        tx_warn, rx_warn, tx_warn | rx_warn};

  // read channel, one cycle from address to data
  logic [7:0] rd_b;
  buf_idx_t   rd_buf;
  logic [7:0] rd_val;
  assign rd_b   = s_axi_araddr - `OFS_BUF_BASE;
  assign rd_buf = buf_idx_t'(rd_b >> 6);
  always_comb begin
    rd_val = 8'h00;
    case (s_axi_araddr)
      `OFS_STATUS:   rd_val = comm_status;
      `OFS_TX_COUNT: rd_val = tec_reg;
      `OFS_MODCTRL:  rd_val = {3'b000, abort_all_reg, 4'h0};
      `OFS_RXERRCNT: rd_val = rx_error_count;
      default: if (addr_hit(s_axi_araddr)) begin
        case (rd_b[5:2])
          `BOFS_CON:  rd_val = {1'b0, abt_reg[rd_buf], larb_reg[rd_buf], err_reg[rd_buf],
                                req_reg[rd_buf], 1'b0, pri_reg[rd_buf]};
          `BOFS_SIDH: rd_val = id_high_reg[rd_buf];
          `BOFS_SIDL: rd_val = id_low_reg[rd_buf];
          `BOFS_EIDH: rd_val = eid_high_reg[rd_buf];
          `BOFS_EIDL: rd_val = eid_low_reg[rd_buf];
          `BOFS_DLC:  rd_val = dlc_reg[rd_buf];
          default:    rd_val = data_reg[rd_buf][rd_b[4:2]];
        endcase
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_val};
      s_axi_rresp  <= addr_hit(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // can_tx_buffers

// File: can_tx_buffers_sva.sv
// port-level property checker for the can transmit buffer block
`timescale 1ns/10ps
module can_tx_buffers_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        frame_valid,
  input wire logic        frame_ready,
  input wire logic [10:0] frame_standard_id,
  input wire logic [17:0] frame_extended_id,
  input wire logic        frame_extended,
  input wire logic        frame_sent,
  input wire logic        abort_request,
  input wire logic        abort_ack
);
  logic [7:0] rd_addr_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_addr_reg <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_warn_combined: assert property (s_axi_rvalid && rd_addr_reg == 8'h00 |-> s_axi_rdata[0] == (s_axi_rdata[2] | s_axi_rdata[1]))
    else $error("combined warning mismatch");
  a_std_no_ext: assert property (frame_valid && !frame_extended |-> frame_extended_id == 18'h0)
    else $error("extended bits leak into standard frame");
  a_id_stable: assert property (frame_valid && !frame_ready |=> !frame_valid || $stable(frame_standard_id))
    else $error("identifier moved while offered");
  a_abort_release: assert property (abort_request && abort_ack |=> !abort_request)
    else $error("abort request held after ack");
  a_sent_ends: assert property (frame_sent |=> !frame_valid [*2])
    else $error("frame offered again right after success");
endmodule // can_tx_buffers_sva
bind can_tx_buffers can_tx_buffers_sva sva_inst (.*);

// File: can_engine_model.sv
// behavioural protocol engine standing in for the other bus nodes
`timescale 1ns/10ps
module can_engine_model (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       frame_valid,
  input wire logic       abort_request,
  input wire logic [1:0] outcome,
  input wire logic [3:0] hold_cycles,
  output logic           frame_ready,
  output logic           frame_sent,
  output logic           frame_lost_arbitration,
  output logic           frame_bus_error,
  output logic           abort_ack
);
  logic [3:0] wait_reg;
  logic       busy_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {frame_ready, frame_sent, frame_lost_arbitration, frame_bus_error, abort_ack} <= '0;
      wait_reg <= 4'h0;
      busy_reg <= 1'b0;
    end else begin
      {frame_sent, frame_lost_arbitration, frame_bus_error, abort_ack} <= '0;
      if (frame_ready && frame_valid) begin
        frame_ready <= 1'b0;
        busy_reg <= 1'b1;
        wait_reg <= 4'h0;
      end else if (busy_reg) begin
        wait_reg <= wait_reg + 4'h1;
        // an abort wins over any outcome, as a real engine stops at once
        if (abort_request || wait_reg == 4'h6) begin
          busy_reg <= 1'b0;
          abort_ack <= abort_request;
          frame_sent <= !abort_request && outcome == 2'd0;
          frame_lost_arbitration <= !abort_request && outcome == 2'd1;
          frame_bus_error <= !abort_request && outcome == 2'd2;
        end
      end else if (frame_valid && !frame_ready) begin
        wait_reg <= wait_reg + 4'h1;
        frame_ready <= wait_reg >= hold_cycles;
      end else wait_reg <= 4'h0;
    end
  end
endmodule // can_engine_model

// File: can_tx_buffers_error_status_bench.sv
// self-checking bench for the can transmit buffers with a reference model
`timescale 1ns/10ps
module can_tx_buffers_error_status_bench;
  import can_tx_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, frame_valid, frame_ready, frame_extended, frame_remote;
  logic        frame_sent, frame_lost_arbitration, frame_bus_error, abort_ack, abort_request;
  logic        rx_buf0_overflow_event, rx_buf1_overflow_event, tec_increment_8;
  logic        tec_increment_1, tec_decrement, recessive_run_11;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_error_count;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, frame_length, hold_cycles;
  logic [1:0]  s_axi_bresp, s_axi_rresp, outcome;
  logic [10:0] frame_standard_id;
  logic [17:0] frame_extended_id;
  logic [63:0] frame_data;
  buf_idx_t    frame_buffer;
  logic [5:0]  pulse_bus;
  logic [7:0]  hi[3], lo[3], xh[3], xl[3], dl[3];
  logic [63:0] dat[3];
  int          err_count, check_count, ends, seen_q[$], exp_q[$];
  int          pri[3] = '{1, 3, 3};
  int          rx_tbl[6] = '{0, 95, 96, 127, 128, 255};
  assign {recessive_run_11, tec_decrement, tec_increment_1, tec_increment_8,
          rx_buf1_overflow_event, rx_buf0_overflow_event} = pulse_bus;
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  can_tx_buffers uut (.*);
  can_engine_model peer (.*);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, 2'b00);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask
  task automatic pulse(input logic [5:0] m, input int n);
    repeat (n) begin
      @(posedge aclk);
      pulse_bus <= m;
      @(posedge aclk);
      pulse_bus <= 6'h00;
    end
  endtask
  // bounded: an abort that completes at once gives no end pulse to wait for
  task automatic wait_ends(input int n);
    int t0;
    t0 = ends + n;
    for (int i = 0; i < 400 && ends < t0; i++) @(posedge aclk);
  endtask
  function automatic logic [31:0] status(int t, int r, logic [1:0] ov);
    logic tw;
    logic rw;
    tw = t > 95 && t <= 127;
    rw = r > 95 && r <= 127;
    return {24'h0, ov, t > 255, t > 127, r > 127, tw, rw, tw | rw};
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge aclk) begin : monitor
    int b;
    logic [63:0] m;
    ends += frame_sent | frame_lost_arbitration | frame_bus_error | abort_ack;
    if (frame_valid && frame_ready) begin
      b = frame_buffer;
      seen_q.push_back(b);
      m = dl[b][3:0] >= 4'h8 ? '1 : (64'h1 << (8 * dl[b][3:0])) - 64'h1;
      chk(frame_standard_id, {hi[b], lo[b][7:5]});
      chk(frame_extended, lo[b][3]);
      chk(frame_extended_id, lo[b][3] ? {lo[b][1:0], xh[b], xl[b]} : 18'h0);
      chk(frame_remote, dl[b][6]);
      chk(frame_length, dl[b][3:0]);
      chk(frame_data & m, dat[b] & m);
    end
  end
  initial begin
    int v;
    int r;
    logic [7:0] b;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_error_count} = '0;
    s_axi_wstrb = 4'h1;
    {pulse_bus, outcome, hold_cycles} = '0;
    void'($urandom(72422));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 0);
    rd(8'h04, 0);
    rd(8'h40, 0);
    rd(8'h30, 0, 2'b10);
    for (int i = 0; i < 8; i++) begin
      v = i < 6 ? rx_tbl[i] : $urandom_range(255);
      rx_error_count <= 8'(v);
      rd(8'h00, status(0, v, 2'b00));
    end
    rx_error_count <= 8'h00;
    pulse(6'h03, 1);
    rd(8'h00, status(0, 0, 2'b11));
    wr(8'h00, 8'hbf);
    rd(8'h00, status(0, 0, 2'b01));
    wr(8'h00, 8'h40);
    rd(8'h00, 0);
    pulse(6'h04, 12);
    rd(8'h04, 96);
    rd(8'h00, status(96, 0, 0));
    pulse(6'h10, 1);
    rd(8'h00, status(95, 0, 0));
    pulse(6'h08, 32);
    rd(8'h00, status(127, 0, 0));
    pulse(6'h08, 1);
    rd(8'h04, 128);
    rd(8'h00, status(128, 0, 0));
    pulse(6'h04, 16);
    rd(8'h00, status(256, 0, 0));
    pulse(6'h20, 127);
    rd(8'h00, status(256, 0, 0));
    pulse(6'h20, 1);
    rd(8'h04, 0);
    rd(8'h00, 0);
    for (int n = 0; n < 3; n++) begin
      hi[n] = 8'($urandom);
      lo[n] = (8'($urandom) & 8'he3) | (n == 2 ? 8'h08 : 8'h00);
      xh[n] = 8'($urandom);
      xl[n] = 8'($urandom);
      dl[n] = n == 0 ? 8'h0f : n == 1 ? 8'h08 : 8'h43;
      dat[n] = {$urandom, $urandom};
      b = 8'(64 * n + 64);
      wr(b + 8'h04, hi[n]);
      wr(b + 8'h08, lo[n]);
      wr(b + 8'h0c, xh[n]);
      wr(b + 8'h10, xl[n]);
      wr(b + 8'h14, dl[n]);
      for (int m = 0; m < 8; m++) wr(b + 8'h20 + 8'(4 * m), dat[n][8 * m +: 8]);
    end
    // slow acceptance keeps buffer 0 waiting while the others are queued
    hold_cycles <= 4'hc;
    wr(8'h40, 8'h09);
    wr(8'h80, 8'h0b);
    wr(8'hc0, 8'h0b);
    exp_q = {0};
    for (int k = 0; k < 2; k++) begin
      r = -1;
      for (int n = 1; n < 3; n++) if (!(n inside {exp_q}) && (r < 0 || pri[n] >= pri[r])) r = n;
      exp_q.push_back(r);
    end
    wait_ends(3);
    chk(seen_q.size(), 3);
    for (int k = 0; k < 3; k++) chk(seen_q[k], exp_q[k]);
    for (int n = 0; n < 3; n++) rd(8'(64 * n + 64), 32'(pri[n]));
    hold_cycles <= 4'h0;
    outcome <= 2'd1;
    wr(8'h40, 8'h09);
    wait_ends(2);
    rd(8'h40, 8'h29);
    wr(8'h40, 8'h01);
    wait_ends(1);
    rd(8'h40, 8'h61);
    outcome <= 2'd0;
    wr(8'h40, 8'h09);
    wait_ends(1);
    rd(8'h40, 8'h01);
    outcome <= 2'd2;
    wr(8'h80, 8'h08);
    wait_ends(2);
    rd(8'h80, 8'h18);
    wr(8'h08, 8'h10);
    wait_ends(1);
    rd(8'h80, 8'h50);
    rd(8'h08, 0);
    end_sim();
  end
  initial begin
    #3_000_000;
    err_count++;
    end_sim();
  end
endmodule // can_tx_buffers_error_status_bench
